// file: common/iao_pkg.sv
// Package with encodings, field positions and carrier types for the increment/OR datapath.
package iao_pkg;
  localparam int        DATA_W    = 16;
  localparam int        FADDR_W   = 13;
  localparam int        WORK_IDX_W = 4;
  localparam int        WORK_REG_N = 16;
  localparam logic [3:0] DEF_WORK_IDX = 4'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] INC_ONE  = 16'h0001;
  localparam logic [15:0] INC_TWO  = 16'h0002;
  localparam logic      WIDTH_WORD = 1'b0;
  localparam logic      WIDTH_BYTE = 1'b1;
  localparam logic      DEST_DEFAULT = 1'b0;
  localparam logic [2:0] MODE_DIRECT   = 3'h0;
  localparam logic [2:0] MODE_IND      = 3'h1;
  localparam logic [2:0] MODE_IND_POSTINC = 3'h2;
  localparam logic [2:0] MODE_IND_POSTDEC = 3'h3;
  localparam logic [2:0] MODE_IND_PREINC  = 3'h4;
  localparam logic [2:0] MODE_IND_PREDEC  = 3'h5;
  localparam int C_BIT      = 0;
  localparam int Z_BIT      = 1;
  localparam int OVF_BIT    = 2;
  localparam int N_BIT      = 3;
  localparam int HALF_C_BIT = 8;

  typedef enum logic [2:0] {
    IAO_OP_INC_W  = 3'b000,
    IAO_OP_INC_TWO_F = 3'b001,
    IAO_OP_INC_TWO_W = 3'b010,
    IAO_OP_IOR_F  = 3'b011,
    IAO_OP_IOR_L  = 3'b100,
    IAO_OP_IOR_WW = 3'b101,
    IAO_OP_IOR_WL = 3'b110
  } iao_op_type;

  typedef struct packed {
    iao_op_type        op;
    logic              byte_sel;
    logic              dest_sel;
    logic [12:0]       faddr;
    logic [3:0]        src_reg;
    logic [2:0]        src_mode;
    logic [3:0]        dst_reg;
    logic [2:0]        dst_mode;
    logic [3:0]        base_reg;
    logic [15:0]       literal;
  } iao_instr_type;

  typedef struct packed {
    logic        valid;
    logic        to_file;
    logic [15:0] addr;
    logic [15:0] data;
    logic        byte_sel;
  } iao_wr_type;
endpackage

// file: core/iao_addr_unit.sv
// Effective-address and pointer update unit for one register operand.
`timescale 1ns/10ps
module iao_addr_unit (
  input  wire logic [2:0]  mode,
  input  wire logic [15:0] ptr,
  input  wire logic        byte_sel,
  output logic             indirect,
  output logic [15:0]      ea,
  output logic [15:0]      ptr_new
);
  logic [15:0] step;

  always_comb begin
    step     = (byte_sel == iao_pkg::WIDTH_BYTE) ? iao_pkg::INC_ONE : iao_pkg::INC_TWO;
    indirect = (mode != iao_pkg::MODE_DIRECT);
    ea       = ptr;
    ptr_new  = ptr;
    case (mode)
      iao_pkg::MODE_IND_POSTINC: ptr_new = ptr + step;
      iao_pkg::MODE_IND_POSTDEC: ptr_new = ptr - step;
      iao_pkg::MODE_IND_PREINC: begin
        ea      = ptr + step;
        ptr_new = ptr + step;
      end
      iao_pkg::MODE_IND_PREDEC: begin
        ea      = ptr - step;
        ptr_new = ptr - step;
      end
      default: ptr_new = ptr;
    endcase
  end
endmodule

// file: core/iao_core.sv
// Single-cycle increment and inclusive-OR execution datapath with working registers.
`timescale 1ns/10ps
module iao_core (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  clk_en,
  input  wire logic                  instr_valid,
  input  wire iao_pkg::iao_instr_type instr,
  input  wire logic [15:0]           mem_rdata_src,
  output logic [15:0]                mem_addr_src,
  output logic [15:0]                mem_addr_dst,
  output iao_pkg::iao_wr_type        mem_wr,
  output logic [15:0]                default_work_reg,
  output logic [15:0]                status_reg,
  output logic                       done
);
  logic [15:0] regs_q [iao_pkg::WORK_REG_N];
  logic [15:0] status_q;
  logic        done_q;
  iao_pkg::iao_wr_type wr_q;

  logic [15:0] src_ptr, dst_ptr, src_ea, dst_ea, src_upd, dst_upd;
  logic        src_ind, dst_ind;
  logic [15:0] opa, opb, res;
  logic        is_or, to_file, wr_reg, wr_mem;
  logic [3:0]  wr_idx;
  logic [15:0] new_flags;
  logic        res_neg, res_zero, res_c, res_half_c, res_ovf;
  logic [16:0] sum;

  // Merges a byte result into the low lane and keeps the upper byte untouched.
  function automatic logic [15:0] merge_w(input logic [15:0] old, input logic [15:0] v,
                                          input logic bsel);
    merge_w = (bsel == iao_pkg::WIDTH_BYTE) ? {old[15:8], v[7:0]} : v;
  endfunction

  // File forms address data memory through the instruction's file field, not a pointer.
  function automatic logic is_file_op(input iao_pkg::iao_op_type op);
    is_file_op = (op == iao_pkg::IAO_OP_INC_TWO_F) || (op == iao_pkg::IAO_OP_IOR_F);
  endfunction

  assign src_ptr = regs_q[instr.src_reg];
  assign dst_ptr = regs_q[instr.dst_reg];

  iao_addr_unit u_src (
    .mode     (instr.src_mode),
    .ptr      (src_ptr),
    .byte_sel (instr.byte_sel),
    .indirect (src_ind),
    .ea       (src_ea),
    .ptr_new  (src_upd)
  );

  iao_addr_unit u_dst (
    .mode     (instr.dst_mode),
    .ptr      (dst_ptr),
    .byte_sel (instr.byte_sel),
    .indirect (dst_ind),
    .ea       (dst_ea),
    .ptr_new  (dst_upd)
  );

  assign mem_addr_src = is_file_op(instr.op) ? {3'h0, instr.faddr} : src_ea;
  assign mem_addr_dst = dst_ea;

  always_comb begin
    is_or   = 1'b0;
    to_file = 1'b0;
    opa     = src_ind ? mem_rdata_src : src_ptr;
    opb     = iao_pkg::INC_ONE;
    case (instr.op)
      iao_pkg::IAO_OP_INC_W:  opb = iao_pkg::INC_ONE;
      iao_pkg::IAO_OP_INC_TWO_W: opb = iao_pkg::INC_TWO;
      iao_pkg::IAO_OP_INC_TWO_F: begin
        opa     = mem_rdata_src;
        opb     = iao_pkg::INC_TWO;
        to_file = (instr.dest_sel != iao_pkg::DEST_DEFAULT);
      end
      iao_pkg::IAO_OP_IOR_F: begin
        opa     = mem_rdata_src;
        opb     = regs_q[iao_pkg::DEF_WORK_IDX];
        is_or   = 1'b1;
        to_file = (instr.dest_sel != iao_pkg::DEST_DEFAULT);
      end
      iao_pkg::IAO_OP_IOR_L: begin
        opa   = dst_ptr;
        opb   = instr.literal;
        is_or = 1'b1;
      end
      iao_pkg::IAO_OP_IOR_WW: begin
        opb   = regs_q[instr.base_reg];
        is_or = 1'b1;
      end
      iao_pkg::IAO_OP_IOR_WL: begin
        opa   = regs_q[instr.base_reg];
        opb   = instr.literal;
        is_or = 1'b1;
      end
      default: opb = iao_pkg::INC_ONE;
    endcase
  end

  always_comb begin
    sum      = {1'b0, opa} + {1'b0, opb};
    res      = is_or ? (opa | opb) : sum[15:0];
    res_half_c = ({1'b0, opa[3:0]} + {1'b0, opb[3:0]}) > 5'h0f;
    if (instr.byte_sel == iao_pkg::WIDTH_BYTE) begin
      res_neg  = res[7];
      res_zero = (res[7:0] == 8'h00);
      res_c    = ({1'b0, opa[7:0]} + {1'b0, opb[7:0]}) > 9'h0ff;
      res_ovf  = ~opa[7] & res[7];
    end else begin
      res_neg  = res[15];
      res_zero = (res == 16'h0000);
      res_c    = sum[16];
      res_ovf  = ~opa[15] & res[15];
    end
    new_flags = status_q;
    new_flags[iao_pkg::N_BIT] = res_neg;
    new_flags[iao_pkg::Z_BIT] = res_zero;
    // The OR forms leave the arithmetic flags alone, so a following add still sees them.
    if (!is_or) begin
      new_flags[iao_pkg::C_BIT]      = res_c;
      new_flags[iao_pkg::OVF_BIT]    = res_ovf;
      new_flags[iao_pkg::HALF_C_BIT] = res_half_c;
    end
  end

  always_comb begin
    wr_mem = 1'b0;
    wr_reg = 1'b0;
    wr_idx = instr.dst_reg;
    case (instr.op)
      iao_pkg::IAO_OP_INC_TWO_F, iao_pkg::IAO_OP_IOR_F: begin
        wr_mem = to_file;
        wr_reg = !to_file;
        wr_idx = iao_pkg::DEF_WORK_IDX;
      end
      default: begin
        wr_mem = dst_ind;
        wr_reg = !dst_ind;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < iao_pkg::WORK_REG_N; i++) begin
        regs_q[i] <= iao_pkg::RST_WORD;
      end
    end else if (clk_en && instr_valid) begin
      // Literal forms name no source pointer, so none is stepped for them.
      if (src_ind && !is_file_op(instr.op) && instr.op != iao_pkg::IAO_OP_IOR_L
          && instr.op != iao_pkg::IAO_OP_IOR_WL) begin
        regs_q[instr.src_reg] <= src_upd;
      end
      if (dst_ind && !wr_reg) begin
        regs_q[instr.dst_reg] <= dst_upd;
      end
      if (wr_reg) begin
        regs_q[wr_idx] <= merge_w(regs_q[wr_idx], res, instr.byte_sel);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= iao_pkg::RST_WORD;
    end else if (clk_en && instr_valid) begin
      status_q <= new_flags;
    end
  end

  // Memory write is registered so the data port sees a clean one-cycle strobe.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q   <= '0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q         <= instr_valid;
      wr_q.valid     <= instr_valid && wr_mem;
      wr_q.to_file   <= to_file;
      wr_q.addr      <= to_file ? {3'h0, instr.faddr} : dst_ea;
      wr_q.data      <= res;
      wr_q.byte_sel  <= instr.byte_sel;
    end
  end

  assign mem_wr           = wr_q;
  assign default_work_reg = regs_q[iao_pkg::DEF_WORK_IDX];
  assign status_reg       = status_q;
  assign done             = done_q;

  sequence s_exec;
    clk_en && instr_valid;
  endsequence

  sequence s_exec_direct_word;
    clk_en && instr_valid && instr.src_mode == iao_pkg::MODE_DIRECT
    && instr.dst_mode == iao_pkg::MODE_DIRECT && instr.dst_reg == iao_pkg::DEF_WORK_IDX
    && instr.byte_sel == iao_pkg::WIDTH_WORD;
  endsequence

  a_or_flags_only: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_exec ##0 is_or)
    |=> (status_q[iao_pkg::C_BIT] == $past(status_q[iao_pkg::C_BIT])
         && status_q[iao_pkg::OVF_BIT] == $past(status_q[iao_pkg::OVF_BIT])
         && status_q[iao_pkg::HALF_C_BIT] == $past(status_q[iao_pkg::HALF_C_BIT])))
    else $error("OR changed an arithmetic flag");
  a_file_to_default: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_exec ##0 (instr.op == iao_pkg::IAO_OP_INC_TWO_F
                 && instr.dest_sel == iao_pkg::DEST_DEFAULT
                 && instr.byte_sel == iao_pkg::WIDTH_WORD))
    |=> (default_work_reg == $past(mem_rdata_src) + iao_pkg::INC_TWO))
    else $error("file increment by two not in default register");
  a_file_wr_strobe: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_exec ##0 (instr.op == iao_pkg::IAO_OP_INC_TWO_F
                 && instr.dest_sel != iao_pkg::DEST_DEFAULT))
    |=> (mem_wr.valid && mem_wr.data == $past(mem_rdata_src) + iao_pkg::INC_TWO))
    else $error("file increment by two not written back");
  a_done_follows: assert property (@(posedge core_clk) disable iff (!nrst)
    s_exec |=> done)
    else $error("done missing after instruction");
  a_inc_one_direct: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_exec_direct_word ##0 (instr.op == iao_pkg::IAO_OP_INC_W))
    |=> (default_work_reg == $past(src_ptr) + iao_pkg::INC_ONE))
    else $error("increment by one result wrong");
  a_inc_two_direct: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_exec_direct_word ##0 (instr.op == iao_pkg::IAO_OP_INC_TWO_W))
    |=> (default_work_reg == $past(src_ptr) + iao_pkg::INC_TWO))
    else $error("register increment by two result wrong");
  a_ind_dest_write: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_exec ##0 (dst_ind && !is_file_op(instr.op)))
    |=> (mem_wr.valid && mem_wr.addr == $past(dst_ea)))
    else $error("indirect destination not written");
  a_byte_upper_kept: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_exec ##0 (wr_reg && wr_idx == iao_pkg::DEF_WORK_IDX
                 && instr.byte_sel == iao_pkg::WIDTH_BYTE))
    |=> (default_work_reg[15:8] == $past(default_work_reg[15:8])))
    else $error("byte write disturbed the upper byte");
endmodule

// file: dv/tb_increment_and_or_execute.sv
// Self-checking testbench for the increment and inclusive-OR datapath.
`timescale 1ns/10ps
module tb_increment_and_or_execute;
  logic                   core_clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   clk_en = 1'b1;
  logic                   instr_valid = 1'b0;
  iao_pkg::iao_instr_type instr = '0;
  logic [15:0]            rdata = 16'h0000;
  iao_pkg::iao_wr_type    wr;
  logic [15:0]            w0;
  logic [15:0]            status;
  logic [15:0]            addr_src;
  logic [15:0]            addr_dst;
  logic [15:0]            src_seen = 16'h0000;
  logic [15:0]            dst_seen = 16'h0000;
  logic                   done;
  int                     error_cnt = 0;
  int                     checks = 0;
  int                     cycles = 0;

  always #5 core_clk = ~core_clk;

  iao_core i_dut (
    .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .instr_valid(instr_valid),
    .instr(instr), .mem_rdata_src(rdata), .mem_addr_src(addr_src),
    .mem_addr_dst(addr_dst), .mem_wr(wr), .default_work_reg(w0),
    .status_reg(status), .done(done)
  );

  task automatic report_and_stop();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // All register fields point at the default register, so its value is visible.
  task automatic run(input iao_pkg::iao_op_type op, input logic bsel, input logic dsel,
                     input logic [2:0] sm, input logic [2:0] dm, input logic [15:0] lit,
                     input logic [15:0] data);
    iao_pkg::iao_instr_type v;
    v = '{op, bsel, dsel, 13'h0123, 4'h0, sm, 4'h0, dm, 4'h0, lit};
    @(posedge core_clk);
    instr <= v;
    instr_valid <= 1'b1;
    rdata <= data;
    #1;
    src_seen = addr_src;
    dst_seen = addr_dst;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic t_or_forms();
    run(iao_pkg::IAO_OP_IOR_F, 1'b0, 1'b0, 3'h0, 3'h0, 16'h0000, 16'h0000);
    chk(w0, 16'h0000);
    chk(status & 16'h000a, 16'h0002);
    chk({15'h0000, done}, 16'h0001);
    run(iao_pkg::IAO_OP_IOR_F, 1'b0, 1'b0, 3'h0, 3'h0, 16'h0000, 16'h0f00);
    chk(w0, 16'h0f00);
    run(iao_pkg::IAO_OP_IOR_L, 1'b0, 1'b0, 3'h0, 3'h0, 16'h00aa, 16'h0000);
    chk(w0, 16'h0faa);
    run(iao_pkg::IAO_OP_IOR_WL, 1'b0, 1'b0, 3'h0, 3'h0, 16'h0015, 16'h0000);
    chk(w0, 16'h0fbf);
    run(iao_pkg::IAO_OP_IOR_WW, 1'b0, 1'b0, 3'h1, 3'h0, 16'h0000, 16'h8000);
    chk(src_seen, 16'h0fbf);
    chk(w0, 16'h8fbf);
    chk(status & 16'h000a, 16'h0008);
    run(iao_pkg::IAO_OP_IOR_F, 1'b0, 1'b1, 3'h0, 3'h0, 16'h0000, 16'h1000);
    chk({15'h0000, wr.valid}, 16'h0001);
    chk(wr.addr, 16'h0123);
    chk(wr.data, 16'h9fbf);
    chk(src_seen, 16'h0123);
    chk({15'h0000, wr.to_file}, 16'h0001);
    chk(w0, 16'h8fbf);
    run(iao_pkg::IAO_OP_IOR_L, 1'b1, 1'b0, 3'h0, 3'h0, 16'h0040, 16'h0000);
    chk(w0, 16'h8fff);
    $display("or forms test done");
  endtask

  task automatic t_inc_one();
    run(iao_pkg::IAO_OP_INC_TWO_W, 1'b0, 1'b0, 3'h1, 3'h0, 16'h0000, 16'hff7d);
    chk(w0, 16'hff7f);
    run(iao_pkg::IAO_OP_INC_W, 1'b1, 1'b0, 3'h0, 3'h0, 16'h0000, 16'h0000);
    chk(w0, 16'hff80);
    run(iao_pkg::IAO_OP_INC_W, 1'b0, 1'b0, 3'h0, 3'h0, 16'h0000, 16'h0000);
    chk(w0, 16'hff81);
    $display("increment by one test done");
  endtask

  task automatic t_inc_two();
    run(iao_pkg::IAO_OP_INC_TWO_F, 1'b0, 1'b1, 3'h0, 3'h0, 16'h0000, 16'h8fff);
    chk(src_seen, 16'h0123);
    chk({15'h0000, wr.valid}, 16'h0001);
    chk(wr.addr, 16'h0123);
    chk(wr.data, 16'h9001);
    chk(w0, 16'hff81);
    run(iao_pkg::IAO_OP_INC_TWO_F, 1'b1, 1'b0, 3'h0, 3'h0, 16'h0000, 16'h80fe);
    chk(w0, 16'hff00);
    run(iao_pkg::IAO_OP_INC_TWO_W, 1'b0, 1'b0, 3'h0, 3'h1, 16'h0000, 16'h0000);
    chk(dst_seen, 16'hff00);
    chk({15'h0000, wr.valid}, 16'h0001);
    chk(wr.addr, 16'hff00);
    chk(wr.data, 16'hff02);
    $display("increment by two test done");
  endtask

  // Both pointer fields name one register; its destination step is applied last.
  task automatic t_ind_modes();
    run(iao_pkg::IAO_OP_INC_W, 1'b0, 1'b0, 3'h4, 3'h3, 16'h0000, 16'h1234);
    chk(src_seen, 16'hff02);
    chk(dst_seen, 16'hff00);
    chk(wr.addr, 16'hff00);
    chk(wr.data, 16'h1235);
    chk(w0, 16'hfefe);
    run(iao_pkg::IAO_OP_INC_W, 1'b1, 1'b0, 3'h5, 3'h2, 16'h0000, 16'h12ff);
    chk(src_seen, 16'hfefd);
    chk(dst_seen, 16'hfefe);
    chk({15'h0000, wr.byte_sel}, 16'h0001);
    chk({15'h0000, wr.to_file}, 16'h0000);
    chk(wr.data, 16'h1300);
    chk(status & 16'h0002, 16'h0002);
    chk(w0, 16'hfeff);
    run(iao_pkg::IAO_OP_INC_TWO_W, 1'b0, 1'b0, 3'h0, 3'h0, 16'h0000, 16'h0000);
    chk(w0, 16'hff01);
    $display("pointer modes test done");
  endtask

  // With the enable low an offered instruction must leave no trace.
  task automatic t_clk_en_hold();
    @(posedge core_clk);
    clk_en <= 1'b0;
    run(iao_pkg::IAO_OP_INC_W, 1'b0, 1'b0, 3'h0, 3'h0, 16'h0000, 16'h0000);
    chk(w0, 16'hff01);
    chk({15'h0000, done}, 16'h0000);
    @(posedge core_clk);
    clk_en <= 1'b1;
    run(iao_pkg::IAO_OP_INC_W, 1'b0, 1'b0, 3'h0, 3'h0, 16'h0000, 16'h0000);
    chk(w0, 16'hff02);
    $display("clock enable test done");
  endtask

  // The whole run needs well under a hundred cycles; this ceiling catches a hang.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    #1;
    chk(w0, 16'h0000);
    chk(status, 16'h0000);
    chk({15'h0000, wr.valid}, 16'h0000);
    t_or_forms();
    t_inc_one();
    t_inc_two();
    t_ind_modes();
    t_clk_en_hold();
    report_and_stop();
  end
endmodule
